// ===== frab_core.sv
// Purpose: execute clear, decrement, skip, jump and or-literal instructions
// Assumes: one instruction per mclk cycle, data memory read combinationally
// Notes:   flag storage lives outside; this block only reports updates
//
// Overview of operation
// - clear_file_reg writes zero to the addressed register and sets the null flag.
// - decrement_file_reg subtracts one, routes by the destination bit, updates the null flag.
// - clear_accumulator loads zero into the accumulator and sets the null flag.
// - decrement_skip_if_null decrements, routes by destination, skips next if zero, no flags.
// - increment_skip_if_null increments, routes by destination, skips next if zero, no flags.
// - absolute_jump loads the 11-bit literal into pc 10:0 and latch-high bits 4:3 into 12:11.
// - absolute_jump always takes two cycles so the prefetched word is not executed.
// - or_literal_into_accumulator ORs the literal into the accumulator and updates the flag.
module frab_core
   import frab_pkg::*;
(
   input  wire logic                        mclk,
   input  wire logic                        rst_b,
   input  wire logic [frab_pkg::INSN_W-1:0] insn,
   input  wire logic                        insn_valid,
   input  wire logic [frab_pkg::DATA_W-1:0] file_rdata,
   input  wire logic [frab_pkg::DATA_W-1:0] program_counter_latch_high,
   output logic      [frab_pkg::ADDR_W-1:0] file_addr,
   output logic      [frab_pkg::DATA_W-1:0] file_wdata,
   output logic                             file_we,
   output logic      [frab_pkg::DATA_W-1:0] acc,
   output logic                             null_flag_we,
   output logic                             null_flag,
   output logic      [frab_pkg::PC_W-1:0]   pc,
   output logic                             flush
);
   import frab_pkg::*;

   // -------------------------------------------------------------------------
   // reset release
   // -------------------------------------------------------------------------
   logic rst_meta;
   logic rst_sync;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // -------------------------------------------------------------------------
   // decode
   // -------------------------------------------------------------------------
   frab_op_t op;

   frab_decode u_decode (
      .insn (insn),
      .op   (op)
   );

   // -------------------------------------------------------------------------
   // execute
   // -------------------------------------------------------------------------
   logic              live;
   logic              to_file;
   logic [DATA_W-1:0] result;
   logic              result_null;

   // a slot marked by flush is the forced no-operation of a skip or a jump
   assign live    = insn_valid && !flush;
   assign to_file = insn[DEST_BIT];

   always_comb begin
      result = ZERO_BYTE;
      case (op)
         FRAB_DEC, FRAB_DECSKP: begin
            result = DATA_W'(file_rdata - 8'h01);
         end
         FRAB_INCSKP: begin
            result = DATA_W'(file_rdata + 8'h01);
         end
         FRAB_OR_LIT: begin
            result = acc | insn[DATA_W-1:0];
         end
         default: begin
            result = ZERO_BYTE;
         end
      endcase
   end

   // one zero detector serves every computed flag and every skip
   assign result_null = (result == ZERO_BYTE);

   // -------------------------------------------------------------------------
   // accumulator
   // -------------------------------------------------------------------------
   logic [DATA_W-1:0] next_acc;

   always_comb begin
      next_acc = acc;
      if (live) begin
         case (op)
            FRAB_CLR_ACC: begin
               next_acc = ZERO_BYTE;
            end
            FRAB_DEC, FRAB_DECSKP, FRAB_INCSKP: begin
               if (!to_file) begin
                  next_acc = result;
               end
            end
            FRAB_OR_LIT: begin
               next_acc = result;
            end
            default: begin
               next_acc = acc;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_sync) begin
      if (!rst_sync) begin
         acc <= ACC_RESET;
      end else begin
         acc <= next_acc;
      end
   end

   // -------------------------------------------------------------------------
   // data register write port
   // -------------------------------------------------------------------------
   logic [ADDR_W-1:0] next_file_addr;
   logic [DATA_W-1:0] next_file_wdata;
   logic              next_file_we;

   always_comb begin
      next_file_addr  = insn[ADDR_W-1:0];
      next_file_wdata = file_wdata;
      next_file_we    = 1'b0;
      if (live) begin
         case (op)
            FRAB_CLR_FILE: begin
               next_file_wdata = ZERO_BYTE;
               next_file_we    = 1'b1;
            end
            FRAB_DEC, FRAB_DECSKP, FRAB_INCSKP: begin
               if (to_file) begin
                  next_file_wdata = result;
                  next_file_we    = 1'b1;
               end
            end
            default: begin
               next_file_we = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_sync) begin
      if (!rst_sync) begin
         file_addr  <= '0;
         file_wdata <= ZERO_BYTE;
         file_we    <= 1'b0;
      end else begin
         file_addr  <= next_file_addr;
         file_wdata <= next_file_wdata;
         file_we    <= next_file_we;
      end
   end

   // -------------------------------------------------------------------------
   // null flag report
   // -------------------------------------------------------------------------
   logic next_null_flag_we;
   logic next_null_flag;

   always_comb begin
      next_null_flag_we = 1'b0;
      next_null_flag    = null_flag;
      if (live) begin
         case (op)
            FRAB_CLR_FILE, FRAB_CLR_ACC: begin
               next_null_flag_we = 1'b1;
               next_null_flag    = 1'b1;
            end
            FRAB_DEC, FRAB_OR_LIT: begin
               next_null_flag_we = 1'b1;
               next_null_flag    = result_null;
            end
            default: begin
               // skips and jumps leave the flag alone
               next_null_flag_we = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_sync) begin
      if (!rst_sync) begin
         null_flag_we <= 1'b0;
         null_flag    <= 1'b0;
      end else begin
         null_flag_we <= next_null_flag_we;
         null_flag    <= next_null_flag;
      end
   end

   // -------------------------------------------------------------------------
   // program counter and slot drop
   // -------------------------------------------------------------------------
   logic [PC_W-1:0] next_pc;
   logic            next_flush;

   always_comb begin
      next_pc    = pc;
      next_flush = 1'b0;
      if (insn_valid) begin
         // a dropped slot still costs its cycle, so the counter moves on
         next_pc = PC_W'(pc + 13'h0001);
      end
      if (live) begin
         case (op)
            FRAB_DECSKP, FRAB_INCSKP: begin
               // a zero result kills the word already fetched
               next_flush = result_null;
            end
            FRAB_JUMP: begin
               next_pc    = {program_counter_latch_high[JUMP_HI_LO+1:JUMP_HI_LO],
                             insn[LIT_W-1:0]};
               next_flush = 1'b1;
            end
            default: begin
               next_flush = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_sync) begin
      if (!rst_sync) begin
         pc    <= PC_RESET;
         flush <= 1'b0;
      end else begin
         pc    <= next_pc;
         flush <= next_flush;
      end
   end
endmodule : frab_core

// ===== frab_pkg.sv
// Purpose: shared constants for the file-register alu and branch executor
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter
// Notes:   opcode patterns follow the usual mid-range encoding
package frab_pkg;
   // -------------------------------------------------------------------------
   // widths
   // -------------------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int INSN_W = 14;
   localparam int PC_W   = 13;
   localparam int LIT_W  = 11;

   // -------------------------------------------------------------------------
   // opcode fields
   // -------------------------------------------------------------------------
   localparam int DEST_BIT   = 7;
   localparam int JUMP_HI_LO = 3;

   localparam logic [5:0] OP_BYTE_DEC    = 6'h03;
   localparam logic [5:0] OP_BYTE_DECSKP = 6'h0b;
   localparam logic [5:0] OP_BYTE_INCSKP = 6'h0f;
   localparam logic [6:0] OP_CLR_FILE    = 7'h03;
   localparam logic [6:0] OP_CLR_ACC     = 7'h02;
   localparam logic [2:0] OP_JUMP        = 3'h5;
   localparam logic [5:0] OP_OR_LIT      = 6'h38;

   // -------------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------------
   localparam logic [7:0]  ACC_RESET  = 8'h00;
   localparam logic [12:0] PC_RESET   = 13'h0000;
   localparam logic [7:0]  ZERO_BYTE  = 8'h00;

   typedef enum logic [2:0] {
      FRAB_OTHER, FRAB_CLR_FILE, FRAB_DEC, FRAB_CLR_ACC,
      FRAB_DECSKP, FRAB_INCSKP, FRAB_JUMP, FRAB_OR_LIT
   } frab_op_t;
endpackage : frab_pkg

// ===== frab_decode.sv
// Purpose: classify one instruction word into the handled operations
// Assumes: word is stable for the whole cycle
// Notes:   anything unhandled classifies as other and has no effect here
module frab_decode
   import frab_pkg::*;
(
   input  wire logic [frab_pkg::INSN_W-1:0] insn,
   output frab_pkg::frab_op_t               op
);
   always_comb begin
      op = FRAB_OTHER;
      if (insn[13:7] == OP_CLR_FILE) begin
         op = FRAB_CLR_FILE;
      end else if (insn[13:2] == {OP_CLR_ACC, 5'h00}) begin
         op = FRAB_CLR_ACC;
      end else if (insn[13:8] == OP_BYTE_DEC) begin
         op = FRAB_DEC;
      end else if (insn[13:8] == OP_BYTE_DECSKP) begin
         op = FRAB_DECSKP;
      end else if (insn[13:8] == OP_BYTE_INCSKP) begin
         op = FRAB_INCSKP;
      end else if (insn[13:11] == OP_JUMP) begin
         op = FRAB_JUMP;
      end else if (insn[13:8] == OP_OR_LIT) begin
         op = FRAB_OR_LIT;
      end
   end
endmodule : frab_decode

// ===== frab_properties.sv
// Purpose: concurrent checks on the executor ports
// Assumes: no slot is offered before the reset synchroniser lets go
// Notes:   opcodes are decoded here from the package patterns
module frab_properties
   import frab_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic [13:0] insn,
   input wire logic        insn_valid,
   input wire logic [7:0]  file_rdata,
   input wire logic [7:0]  program_counter_latch_high,
   input wire logic [6:0]  file_addr,
   input wire logic [7:0]  file_wdata,
   input wire logic        file_we,
   input wire logic [7:0]  acc,
   input wire logic        null_flag_we,
   input wire logic        null_flag,
   input wire logic [12:0] pc,
   input wire logic        flush
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       take;
   logic [5:0] op6;
   assign take = insn_valid && !flush;
   assign op6  = insn[13:8];
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------------
   sequence s_take_jump;
      take && insn[13:11] == OP_JUMP;
   endsequence
   a_clear_file_zero: assert property (
      take && insn[13:7] == OP_CLR_FILE |=> file_we && file_wdata == 8'h00 && null_flag_we
      && null_flag && file_addr == $past(insn[6:0])) else $error("clear file wrong");
   a_dec_route_flag: assert property (
      take && op6 == OP_BYTE_DEC |=> null_flag_we && file_we == $past(insn[7])
      && null_flag == ($past(file_rdata) == 8'h01)
      && (file_we ? file_wdata : acc) == $past(file_rdata) - 8'h01) else $error("dec wrong");
   a_clear_acc_zero: assert property (
      take && insn[13:2] == {OP_CLR_ACC, 5'h00} |=> acc == 8'h00 && null_flag_we && null_flag)
      else $error("clear acc wrong");
   a_dec_skip_zero: assert property (
      take && op6 == OP_BYTE_DECSKP |=> !null_flag_we && file_we == $past(insn[7])
      && flush == ($past(file_rdata) == 8'h01)) else $error("dec skip wrong");
   a_inc_skip_zero: assert property (
      take && op6 == OP_BYTE_INCSKP |=> !null_flag_we && file_we == $past(insn[7])
      && flush == ($past(file_rdata) == 8'hff)) else $error("inc skip wrong");
   a_jump_target: assert property (
      s_take_jump |=> !null_flag_we && pc == {$past(program_counter_latch_high[4:3]),
      $past(insn[10:0])}) else $error("jump target wrong");
   // the slot behind a jump is dropped, and only that one
   a_jump_two_cycles: assert property (
      s_take_jump |=> flush ##1 !flush) else $error("jump timing wrong");
   a_or_lit_flag: assert property (
      take && op6 == OP_OR_LIT |=> acc == ($past(acc) | $past(insn[7:0])) && null_flag_we
      && null_flag == (acc == 8'h00)) else $error("or literal wrong");
endmodule : frab_properties

// ===== test_file_reg_alu_branch_ops.sv
// Purpose: directed regression of the file-register executor
// Assumes: first slot offered well after the reset synchroniser lets go
// Notes:   each step offers a word and one follow-up, so skips show in acc
module test_file_reg_alu_branch_ops;
   import frab_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic [13:0] insn = 14'h0000;
   logic        insn_valid = 1'b0;
   logic [7:0]  file_rdata = 8'h00;
   logic [7:0]  plh = 8'hf3;
   logic [7:0]  file_wdata, acc, wd;
   logic [6:0]  file_addr, wa;
   logic        file_we, null_flag_we, null_flag, flush;
   logic [12:0] pc;
   int          mismatches = 0;
   int          check_count = 0;
   frab_core i_dut (.mclk(mclk), .rst_b(rst_b), .insn(insn), .insn_valid(insn_valid),
      .file_rdata(file_rdata), .program_counter_latch_high(plh), .file_addr(file_addr),
      .file_wdata(file_wdata), .file_we(file_we), .acc(acc), .null_flag_we(null_flag_we),
      .null_flag(null_flag), .pc(pc), .flush(flush));
   initial forever #4 mclk = ~mclk;
   // write pulses last one cycle, so keep the last one for later checks
   always @(posedge mclk) if (file_we) begin
      wa <= file_addr;
      wd <= file_wdata;
   end
   // ----------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic step(input logic [13:0] w, input logic [7:0] rd, input logic [13:0] nxt);
      @(posedge mclk);
      insn <= w;
      file_rdata <= rd;
      insn_valid <= 1'b1;
      @(posedge mclk);
      insn <= nxt;
      @(posedge mclk);
      insn_valid <= 1'b0;
      #1;
   endtask : step
   task automatic t_files;
      step(14'h01ff, 8'h55, 14'h0000);
      chk("clear addr", 13'h7f, {6'h0, wa});
      chk("clear data", 13'h0, {5'h0, wd});
      chk("clear flag", 13'h1, {12'h0, null_flag});
      step(14'h0385, 8'h01, 14'h0000);
      chk("dec to file", 13'h0, {5'h0, wd});
      chk("dec flag", 13'h1, {12'h0, null_flag});
      step(14'h0305, 8'h00, 14'h0000);
      chk("dec to acc", 13'hff, {5'h0, acc});
      chk("dec flag", 13'h0, {12'h0, null_flag});
      $display("done file ops");
   endtask : t_files
   task automatic t_acc;
      step(14'h0103, 8'h00, 14'h0000);
      chk("clear acc", 13'h0, {5'h0, acc});
      chk("clear acc flag", 13'h1, {12'h0, null_flag});
      step(14'h3800, 8'h00, 14'h0000);
      chk("or zero flag", 13'h1, {12'h0, null_flag});
      step(14'h38a5, 8'h00, 14'h0000);
      chk("or acc", 13'ha5, {5'h0, acc});
      chk("or flag", 13'h0, {12'h0, null_flag});
      $display("done acc ops");
   endtask : t_acc
   // follow-up word ors 11 into acc, so a dropped slot leaves acc alone
   task automatic t_skips;
      step(14'h0b90, 8'h01, 14'h3811);
      chk("dec skip file", 13'h0, {5'h0, wd});
      chk("dec skip acc", 13'ha5, {5'h0, acc});
      chk("dec skip flag", 13'h0, {12'h0, null_flag});
      step(14'h0f92, 8'hfe, 14'h3811);
      chk("inc no skip", 13'hb5, {5'h0, acc});
      step(14'h0f12, 8'hff, 14'h3811);
      chk("inc skip acc", 13'h0, {5'h0, acc});
      chk("inc skip flag", 13'h0, {12'h0, null_flag});
      $display("done skips");
   endtask : t_skips
   task automatic t_jump;
      chk("pc count", 13'h0012, pc);
      step(14'h2da5, 8'h00, 14'h3811);
      chk("jump pc", 13'h15a6, pc);
      chk("jump drops next", 13'h0, {5'h0, acc});
      @(posedge mclk);
      plh <= 8'h08;
      step(14'h2801, 8'h00, 14'h3811);
      chk("jump high bits", 13'h0802, pc);
      chk("jump drops again", 13'h0, {5'h0, acc});
      $display("done jump");
   endtask : t_jump
   initial begin
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      t_files;
      t_acc;
      t_skips;
      t_jump;
      close_out;
   end
   // the tests need about 40 cycles; 600 leaves ample margin
   initial begin
      repeat (600) @(posedge mclk);
      mismatches++;
      close_out;
   end
endmodule : test_file_reg_alu_branch_ops
bind frab_core frab_properties u_props (.mclk(mclk), .rst_b(rst_b), .insn(insn),
   .insn_valid(insn_valid), .file_rdata(file_rdata), .file_addr(file_addr),
   .program_counter_latch_high(program_counter_latch_high), .file_wdata(file_wdata),
   .file_we(file_we), .acc(acc), .null_flag_we(null_flag_we), .null_flag(null_flag),
   .pc(pc), .flush(flush));
